// file: include/adc_ctl_pkg.sv
// constants and types shared by both ends of the converter control link
`default_nettype none
package adc_ctl_pkg;
  localparam int RES_W = 12;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam int CLK_PERIOD_NS = 10;
  localparam int START_MIN_NS = 100;
  localparam int START_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_US = 20;
  localparam int LINK_PERIOD_NS = 1600;
  localparam int HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
  localparam logic [DIV_W-1:0] START_LAST = DIV_W'(START_CYC - 1);
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 2'h2;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_W = 2;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  typedef enum logic [2:0]
  {
    ST_DONE = 3'b001,
    ST_RESET = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;
endpackage
`default_nettype wire

// file: include/adc_link_if.sv
// pins between the converter control and the host that commands it
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
  import adc_ctl_pkg::*;
  logic start;
  logic clk_out;
  logic clk_in;
  logic ser_data;
  logic strobe;
  logic eoc;
  logic eoc_n;
  logic [RES_W-1:0] par_data;
  logic msb_n;
  modport dev
  (
    input start, clk_in,
    output clk_out, ser_data, strobe, eoc, eoc_n, par_data, msb_n
  );
  modport host
  (
    output start, clk_in,
    input clk_out, ser_data, strobe, eoc, eoc_n, par_data, msb_n
  );
endinterface
`default_nettype wire

// file: logic/sync2.sv
// two flip-flop synchroniser for levels from another clock domain
`timescale 1ns/10ps
`default_nettype none
module sync2 #(parameter int W = 1)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2
`default_nettype wire

// file: logic/adc_conv_ctl.sv
// converter end: reset on start, bit-per-clock successive approximation
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - host holds start high at least 100 ns
// - start high resets; falling edge starts clocking
// - status high in reset and conversion
// - second status output always inverse
// - decisions shifted out serially, MSB first
// - strobe per bit; data valid at leading edge
// - serial coding straight or offset binary
// - parallel result held until next start
// - parallel result positive true binary codes
// - inverted MSB gives two's complement
// - internal clock output sets conversion rate
// - conversion clocked only from clock input
// - outside clock symmetric, period above minimum
// - host uses inverted status for hold
module adc_conv_ctl
(
  input wire logic clk_sys,
  input wire logic rst_n,
  adc_link_if.dev link,
  input wire logic cmp_above,
  output logic [adc_ctl_pkg::RES_W-1:0] trial_code,
  input wire logic [adc_ctl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_ctl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adc_ctl_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  import adc_ctl_pkg::*;

  logic start_s;
  logic clk_s;
  sync2 #(.W(2)) u_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({link.start, link.clk_in}),
    .q({start_s, clk_s})
  );

  conv_state_t state_r, state_nxt;
  logic start_d_r, start_d_nxt;
  logic clk_d_r, clk_d_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [RES_W-1:0] sar_r, sar_nxt;
  logic [RES_W-1:0] par_r, par_nxt;
  logic msb_n_r, msb_n_nxt;
  logic ser_r, ser_nxt;
  logic pend_r, pend_nxt;
  logic strobe_r, strobe_nxt;
  logic eoc_r, eoc_nxt;
  logic eoc_n_r, eoc_n_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic clk_out_r, clk_out_nxt;
  logic [EV_W-1:0] sts_r, sts_nxt;
  logic [EV_W-1:0] mask_r, mask_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic start_fall, clk_rise, clk_fall;
  logic [EV_W-1:0] ev;

  assign start_fall = start_d_r & ~start_s;
  assign clk_rise = clk_s & ~clk_d_r;
  assign clk_fall = ~clk_s & clk_d_r;

  function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] i);
    bit_mask = RES_W'(1) << i;
  endfunction

  // conversion sequence
  always_comb
  begin
    state_nxt = state_r;
    start_d_nxt = start_s;
    clk_d_nxt = clk_s;
    idx_nxt = idx_r;
    sar_nxt = sar_r;
    par_nxt = par_r;
    ser_nxt = ser_r;
    pend_nxt = pend_r;
    strobe_nxt = strobe_r;
    ev = '0;
    // strobe rises half a link clock after the bit was set, so the data
    // have settled before the leading edge
    if (clk_fall && pend_r)
    begin
      strobe_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
    else if (clk_rise)
    begin
      strobe_nxt = 1'b0;
    end
    unique case (state_r)
      ST_DONE:
      begin
        if (start_s)
        begin
          state_nxt = ST_RESET;
        end
      end
      ST_RESET:
      begin
        pend_nxt = 1'b0;
        strobe_nxt = 1'b0;
        if (start_fall)
        begin
          state_nxt = ST_CONV;
          idx_nxt = MSB_IDX;
          sar_nxt = bit_mask(MSB_IDX);
        end
      end
      ST_CONV:
      begin
        if (start_s)
        begin
          state_nxt = ST_RESET;
          ev[EV_ABORT] = 1'b1;
        end
        else if (clk_rise)
        begin
          // one decision per link clock rise, only from the clock input
          sar_nxt[idx_r] = cmp_above;
          // the sar code is straight or offset binary by analog range only
          ser_nxt = cmp_above;
          pend_nxt = 1'b1;
          if (idx_r == 4'h0)
          begin
            state_nxt = ST_DONE;
            par_nxt = sar_nxt;
            ev[EV_DONE] = 1'b1;
          end
          else
          begin
            idx_nxt = idx_r - 4'h1;
            sar_nxt = sar_nxt | bit_mask(idx_r - 4'h1);
          end
        end
      end
    endcase
  end

  // status pins follow the state; inverted msb follows the parallel result
  always_comb
  begin
    eoc_nxt = (state_nxt != ST_DONE);
    eoc_n_nxt = (state_nxt == ST_DONE);
    msb_n_nxt = ~par_nxt[MSB_IDX];
  end

  // free running internal clock, offered on the clock output pin
  always_comb
  begin
    div_nxt = div_r + DIV_W'(1);
    clk_out_nxt = clk_out_r;
    if (div_r == HALF_LAST)
    begin
      div_nxt = '0;
      clk_out_nxt = ~clk_out_r;
    end
  end

  // register port and interrupt; an event in a clearing read survives
  always_comb
  begin
    sts_nxt = sts_r | ev;
    mask_nxt = mask_r;
    rdata_nxt = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_STATUS:
        begin
          rdata_nxt = DATA_W'(sts_r);
          sts_nxt = ev;
        end
        ADDR_MASK: rdata_nxt = DATA_W'(mask_r);
        ADDR_RESULT: rdata_nxt = DATA_W'(par_r);
        default: rdata_nxt = '0;
      endcase
    end
    if (reg_wr && reg_addr == ADDR_MASK)
    begin
      mask_nxt = reg_wdata[EV_W-1:0];
    end
    irq_nxt = |(sts_nxt & mask_nxt);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_DONE;
      start_d_r <= 1'b0;
      clk_d_r <= 1'b0;
      idx_r <= '0;
      sar_r <= RESULT_RST;
      par_r <= RESULT_RST;
      msb_n_r <= 1'b1;
      ser_r <= 1'b0;
      pend_r <= 1'b0;
      strobe_r <= 1'b0;
      eoc_r <= 1'b0;
      eoc_n_r <= 1'b1;
      div_r <= '0;
      clk_out_r <= 1'b0;
      sts_r <= '0;
      mask_r <= MASK_RST;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      start_d_r <= start_d_nxt;
      clk_d_r <= clk_d_nxt;
      idx_r <= idx_nxt;
      sar_r <= sar_nxt;
      par_r <= par_nxt;
      msb_n_r <= msb_n_nxt;
      ser_r <= ser_nxt;
      pend_r <= pend_nxt;
      strobe_r <= strobe_nxt;
      eoc_r <= eoc_nxt;
      eoc_n_r <= eoc_n_nxt;
      div_r <= div_nxt;
      clk_out_r <= clk_out_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign link.clk_out = clk_out_r;
  assign link.ser_data = ser_r;
  assign link.strobe = strobe_r;
  assign link.eoc = eoc_r;
  assign link.eoc_n = eoc_n_r;
  assign link.par_data = par_r;
  assign link.msb_n = msb_n_r;
  assign trial_code = sar_r;
  assign reg_rdata = rdata_r;
  assign irq = irq_r;
endmodule // adc_conv_ctl
`default_nettype wire

// file: logic/adc_host_ctl.sv
// host end: issues start pulses, feeds the clock input, captures results
`timescale 1ns/10ps
`default_nettype none
module adc_host_ctl
(
  input wire logic clk_sys,
  input wire logic rst_n,
  adc_link_if.host link,
  input wire logic go,
  input wire logic use_ext_clk,
  output logic [adc_ctl_pkg::RES_W-1:0] ser_word,
  output logic [adc_ctl_pkg::RES_W-1:0] par_word,
  output logic word_valid,
  output logic sh_hold
);
  import adc_ctl_pkg::*;

  logic clk_out_s, strobe_s, ser_s, eoc_n_s;
  sync2 #(.W(4)) u_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({link.clk_out, link.strobe, link.ser_data, link.eoc_n}),
    .q({clk_out_s, strobe_s, ser_s, eoc_n_s})
  );

  logic start_r, start_nxt;
  logic [DIV_W-1:0] pw_r, pw_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic ext_r, ext_nxt;
  logic clk_in_r, clk_in_nxt;
  logic stb_d_r, stb_d_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [RES_W-1:0] shift_r, shift_nxt;
  logic [RES_W-1:0] ser_word_r, ser_word_nxt;
  logic [RES_W-1:0] par_word_r, par_word_nxt;
  logic valid_r, valid_nxt;
  logic hold_r, hold_nxt;

  always_comb
  begin
    start_nxt = start_r;
    pw_nxt = pw_r;
    // shortest legal pulse; a longer one only stretches the conversion
    if (start_r)
    begin
      pw_nxt = pw_r + DIV_W'(1);
      if (pw_r == START_LAST)
      begin
        start_nxt = 1'b0;
      end
    end
    else if (go)
    begin
      start_nxt = 1'b1;
      pw_nxt = '0;
    end
    // symmetric outside clock at the fast model's minimum period
    div_nxt = div_r + DIV_W'(1);
    ext_nxt = ext_r;
    if (div_r == HALF_LAST)
    begin
      div_nxt = '0;
      ext_nxt = ~ext_r;
    end
    clk_in_nxt = use_ext_clk ? ext_r : clk_out_s;
    stb_d_nxt = strobe_s;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    ser_word_nxt = ser_word_r;
    par_word_nxt = par_word_r;
    valid_nxt = 1'b0;
    if (start_r)
    begin
      cnt_nxt = '0;
    end
    else if (strobe_s && !stb_d_r)
    begin
      shift_nxt = {shift_r[RES_W-2:0], ser_s};
      cnt_nxt = cnt_r + 4'h1;
      // the last bit is strobed after status drops, so the word is only
      // whole at the final strobe; the parallel lines settled long before
      if (cnt_r == MSB_IDX)
      begin
        ser_word_nxt = {shift_r[RES_W-2:0], ser_s};
        par_word_nxt = link.par_data;
        valid_nxt = 1'b1;
      end
    end
    hold_nxt = ~eoc_n_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_r <= 1'b0;
      pw_r <= '0;
      div_r <= '0;
      ext_r <= 1'b0;
      clk_in_r <= 1'b0;
      stb_d_r <= 1'b0;
      cnt_r <= '0;
      shift_r <= '0;
      ser_word_r <= RESULT_RST;
      par_word_r <= RESULT_RST;
      valid_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      start_r <= start_nxt;
      pw_r <= pw_nxt;
      div_r <= div_nxt;
      ext_r <= ext_nxt;
      clk_in_r <= clk_in_nxt;
      stb_d_r <= stb_d_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ser_word_r <= ser_word_nxt;
      par_word_r <= par_word_nxt;
      valid_r <= valid_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign link.start = start_r;
  assign link.clk_in = clk_in_r;
  assign ser_word = ser_word_r;
  assign par_word = par_word_r;
  assign word_valid = valid_r;
  assign sh_hold = hold_r;
endmodule // adc_host_ctl
`default_nettype wire

// file: test/adc_link_asserts.sv
// concurrent checks on the converter to host link
`timescale 1ns/10ps
`default_nettype none
module adc_link_asserts
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic ser_data,
  input wire logic strobe,
  input wire logic eoc,
  input wire logic eoc_n,
  input wire logic [adc_ctl_pkg::RES_W-1:0] par_data,
  input wire logic msb_n
);
  import adc_ctl_pkg::*;
  localparam int LINK_CYC = 2 * HALF_CYC;
  localparam int CONV_LO = (RES_W - 1) * LINK_CYC;
  // slack covers both synchroniser stages at each end of the span
  localparam int CONV_HI = RES_W * LINK_CYC + 20;
  logic [15:0] busy_r;
  logic [15:0] busy_nxt;
  always_comb
  begin
    busy_nxt = (start || !eoc) ? 16'h0000 : busy_r + 16'h0001;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      busy_r <= 16'h0000;
    else
      busy_r <= busy_nxt;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_start_rise;
    $rose(start);
  endsequence
  sequence s_busy_seen;
    ##3 eoc;
  endsequence
  chk_eoc_compl: assert property (eoc_n == !eoc)
    else $error("status pair not complementary");
  chk_msb_compl: assert property (msb_n == !par_data[RES_W-1])
    else $error("inverted top bit wrong");
  chk_start_busy: assert property (s_start_rise |-> s_busy_seen)
    else $error("status not raised after start");
  chk_reset_hold: assert property (start [*4] |-> eoc)
    else $error("status low while start held");
  chk_start_width: assert property ($fell(start) |-> $past(start, START_CYC))
    else $error("start pulse too short");
  chk_eoc_source: assert property ($rose(eoc) |-> $past(start, 3))
    else $error("status rose without start");
  chk_par_hold: assert property (!$fell(eoc) |-> $stable(par_data))
    else $error("result changed outside completion");
  chk_strobe_valid: assert property ($rose(strobe) |-> $stable(ser_data))
    else $error("serial bit moved at strobe edge");
  chk_conv_span: assert property
    ($fell(eoc) |-> (busy_r >= CONV_LO) && (busy_r <= CONV_HI))
    else $error("conversion length out of range");
endmodule // adc_link_asserts
`default_nettype wire

// file: test/tb_sar_adc_conversion_control.sv
// testbench joining converter and host ends, plus a bench-driven converter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sar_adc_conversion_control;
  import adc_ctl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmp_above;
  logic cmp2;
  logic [RES_W-1:0] trial_code, trial2, ser_word, par_word, v;
  logic [RES_W-1:0] vin = '0;
  logic [RES_W-1:0] vin2 = '0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata, rdata2, rd_val, rd2;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic use_ext_clk = 1'b0;
  logic irq, word_valid, sh_hold;
  int failures = 0;
  int samples_checked = 0;
  adc_link_if adc_link_if_i ();
  adc_link_if adc_link_if_2_i ();
  always #5 clk_sys = ~clk_sys;
  initial adc_link_if_2_i.clk_in = 1'b0;
  initial adc_link_if_2_i.start = 1'b0;
  // free-running bench link clock, edges fall on falling system edges, between rising ones
  always #80 adc_link_if_2_i.clk_in = ~adc_link_if_2_i.clk_in;
  // comparator stand-in settles in the cycle of each new trial code, since
  // a decision may fall in the very cycle after conversion begins
  assign cmp_above = (vin >= trial_code);
  assign cmp2 = (vin2 >= trial2);
  adc_conv_ctl adc_conv_ctl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(adc_link_if_i), .cmp_above(cmp_above), .trial_code(trial_code),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  adc_conv_ctl adc_conv_ctl_2_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(adc_link_if_2_i), .cmp_above(cmp2), .trial_code(trial2),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata2), .irq());
  adc_host_ctl adc_host_ctl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(adc_link_if_i), .go(go), .use_ext_clk(use_ext_clk),
    .ser_word(ser_word), .par_word(par_word), .word_valid(word_valid),
    .sh_hold(sh_hold));
  adc_link_asserts adc_link_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .start(adc_link_if_i.start), .ser_data(adc_link_if_i.ser_data),
    .strobe(adc_link_if_i.strobe), .eoc(adc_link_if_i.eoc),
    .eoc_n(adc_link_if_i.eoc_n), .par_data(adc_link_if_i.par_data),
    .msb_n(adc_link_if_i.msb_n));
  task automatic test_done;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [DATA_W-1:0] exp_sts(input logic d,
                                                 input logic a);
    exp_sts = (DATA_W'(d) << EV_DONE) | (DATA_W'(a) << EV_ABORT);
  endfunction
  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    rd2 = rdata2;
  endtask
  task automatic convert(input logic [RES_W-1:0] x, input logic ext);
    int n;
    n = 0;
    @(posedge clk_sys);
    vin <= x;
    use_ext_clk <= ext;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    while (word_valid !== 1'b1 && n < 4000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 500)
      begin
        `CHK(adc_link_if_i.eoc, 1'b1)
        `CHK(sh_hold, 1'b1)
      end
    end
    `CHK(word_valid, 1'b1)
    `CHK(ser_word, x)
    `CHK(par_word, x)
    `CHK(adc_link_if_i.par_data, x)
    `CHK(adc_link_if_i.msb_n, ~x[RES_W-1])
    `CHK(adc_link_if_i.eoc_n, 1'b1)
  endtask
  task automatic pulse2(input logic [RES_W-1:0] x);
    @(posedge clk_sys);
    vin2 <= x;
    adc_link_if_2_i.start <= 1'b1;
    repeat (10) @(posedge clk_sys);
    adc_link_if_2_i.start <= 1'b0;
  endtask
  initial
  begin
    #400000;
    failures++;
    test_done();
  end
  initial
  begin
    void'($urandom(96561));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_read(ADDR_MASK);
    `CHK(rd_val, DATA_W'(MASK_RST))
    reg_read(ADDR_RESULT);
    `CHK(rd_val, DATA_W'(RESULT_RST))
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : (i == 2) ? 12'h800 :
          (i == 3) ? 12'h7ff : RES_W'($urandom);
      reg_write(ADDR_MASK, DATA_W'(i[1]));
      convert(v, i[0]);
      `CHK(irq, i[1])
      reg_read(ADDR_STATUS);
      `CHK(rd_val, exp_sts(1'b1, 1'b0))
      `CHK(irq, 1'b0)
    end
    reg_write(ADDR_RESULT, 16'h0abc);
    reg_read(ADDR_RESULT);
    `CHK(rd_val, DATA_W'(v))
    reg_read(2'h3);
    `CHK(rd_val, 16'h0000)
    // one full conversion, then a restart in mid-conversion: the finished
    // result must survive the abort
    pulse2(12'h5a5);
    repeat (2100) @(posedge clk_sys);
    #1;
    `CHK(adc_link_if_2_i.par_data, 12'h5a5)
    pulse2(RES_W'($urandom));
    repeat (100) @(posedge clk_sys);
    pulse2(RES_W'($urandom));
    repeat (60) @(posedge clk_sys);
    #1;
    `CHK(adc_link_if_2_i.eoc, 1'b1)
    `CHK(adc_link_if_2_i.par_data, 12'h5a5)
    repeat (2100) @(posedge clk_sys);
    #1;
    `CHK(adc_link_if_2_i.eoc_n, 1'b1)
    `CHK(adc_link_if_2_i.par_data, vin2)
    reg_read(ADDR_STATUS);
    `CHK(rd2, exp_sts(1'b1, 1'b1))
    test_done();
  end
endmodule // tb_sar_adc_conversion_control
`default_nettype wire
